// ### clim_pkg.sv
// package of constants and enumerations for the control line and interface mode logic
package clim_pkg;
  // clock rate and derived counts
  localparam int unsigned CLOCK_HZ = 50000000;
  localparam int unsigned ANALOG_PERIOD_MS = 250;
  localparam int unsigned ANALOG_PERIOD_CYC = CLOCK_HZ / 1000 * ANALOG_PERIOD_MS;
  localparam int unsigned NMEA_RATE_MS_DEFAULT = 10000;
  localparam int unsigned CYC_PER_MS = CLOCK_HZ / 1000;
  localparam int unsigned DEBOUNCE_US = 1000;
  localparam int unsigned DEBOUNCE_CYC = CLOCK_HZ / 1000000 * DEBOUNCE_US;
  // default measurement channel numbers of the analog outputs
  localparam logic [15:0] CHAN_A_DEFAULT = 16'h0190;
  localparam logic [15:0] CHAN_B_DEFAULT = 16'h01f4;
  // control line function selection
  typedef enum logic [2:0]
  {
    CLIM_CTL_OFF,
    CLIM_CTL_HEAT,
    CLIM_CTL_EDGE,
    CLIM_CTL_LEVEL,
    CLIM_CTL_SDI
  } clim_ctl_e;
  // analog output kind
  typedef enum logic [2:0]
  {
    CLIM_AO_I0_20,
    CLIM_AO_I4_20,
    CLIM_AO_V0_10,
    CLIM_AO_V2_10,
    CLIM_AO_FREQ
  } clim_ao_e;
  // serial protocol selection
  typedef enum logic [2:0]
  {
    CLIM_PR_BINARY,
    CLIM_PR_ASCII,
    CLIM_PR_NMEA,
    CLIM_PR_SDI,
    CLIM_PR_MB_RTU,
    CLIM_PR_MB_ASCII
  } clim_proto_e;
endpackage : clim_pkg

// ### clim_core.sv
// mode gating, control line decoding and analog update timing of the wind sensor interfaces
// Function
// - serial link half or full duplex selectable
// - automatic telegrams only in full duplex
// - current output values only in half duplex
// - heating control works in both duplex modes
// - control line NMEA trigger only full duplex
// - SDI-12 mode only in half duplex
// - firmware update accepted only half duplex
// - two analog outputs refreshed every 250ms
// - output A: current, voltage or frequency
// - output B: current or voltage only
// - analog outputs active only with binary protocol
// - default channels 400 and 500, reconfigurable
// - analog output scaling configurable
// - open line high, shorted line low
// - disabled function ignores control line
// - polarity picks level forcing heating off
// - one telegram per selected control edge
// - telegrams repeat while selected level holds
// - control function selectable, heating default
// - automatic telegram interval in ms, default 10000
`timescale 1ns/1ns
module clim_core
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // control pin, high when open, low when shorted to analog_return
  input wire logic i_ctl_pin,
  // configuration
  input wire logic i_full_duplex,
  input wire clim_pkg::clim_proto_e i_protocol,
  input wire clim_pkg::clim_ctl_e i_ctl_func,
  input wire logic i_ctl_polarity,
  input wire logic i_auto_nmea_en,
  input wire logic [15:0] i_nmea_rate_ms,
  input wire clim_pkg::clim_ao_e i_ao_a_kind,
  input wire clim_pkg::clim_ao_e i_ao_b_kind,
  input wire logic [15:0] i_chan_a,
  input wire logic [15:0] i_chan_b,
  input wire logic i_chan_a_set,
  input wire logic i_chan_b_set,
  input wire logic [15:0] i_scale_a,
  input wire logic [15:0] i_scale_b,
  input wire logic [15:0] i_value_a,
  input wire logic [15:0] i_value_b,
  // requests from the link side
  input wire logic i_fw_update_req,
  input wire logic i_auto_tx_req,
  // mode status
  output logic o_half_duplex,
  output logic o_sdi_mode,
  output logic o_fw_update_ok,
  output logic o_fw_update_refused,
  output logic o_auto_tx_ok,
  // control line results
  output logic o_ctl_level,
  output logic o_heat_force_off,
  output logic o_nmea_send,
  // analog outputs
  output logic o_ao_enable,
  output logic o_ao_a_current_ok,
  output logic o_ao_b_current_ok,
  output logic o_ao_update,
  output clim_pkg::clim_ao_e o_ao_a_kind,
  output clim_pkg::clim_ao_e o_ao_b_kind,
  output logic [15:0] o_chan_a,
  output logic [15:0] o_chan_b,
  output logic [31:0] o_ao_a_value,
  output logic [31:0] o_ao_b_value
);
  import clim_pkg::*;

  // all state of the block in one record
  typedef struct packed
  {
    logic sync1;             // first synchroniser stage
    logic sync2;             // second synchroniser stage
    logic [15:0] deb_cnt;    // debounce stability counter
    logic level;             // debounced control level
    logic level_d;           // previous debounced level for edges
    logic [23:0] ana_cnt;    // analog refresh divider
    logic [15:0] ms_cnt;     // cycles within one millisecond
    logic [15:0] rate_cnt;   // milliseconds since last automatic telegram
    logic [15:0] lvl_cnt;    // milliseconds since last level telegram
    logic half_duplex;
    logic sdi_mode;
    logic fw_ok;
    logic fw_refused;
    logic auto_ok;
    logic heat_off;
    logic nmea_send;
    logic ao_enable;
    logic ao_a_cur;
    logic ao_b_cur;
    logic ao_update;
    clim_ao_e a_kind;
    clim_ao_e b_kind;
    logic [15:0] chan_a;
    logic [15:0] chan_b;
    logic [31:0] a_val;
    logic [31:0] b_val;
  } clim_state_s;

  clim_state_s st;       // registered state
  clim_state_s next_st;  // next state

  // derived counts sized for their counters
  localparam logic [15:0] DEB_LAST = 16'(DEBOUNCE_CYC - 1);
  localparam logic [23:0] ANA_LAST = 24'(ANALOG_PERIOD_CYC - 1);
  localparam logic [15:0] MS_LAST = 16'(CYC_PER_MS - 1);

  // next state logic
  always_comb
  begin
    logic ms_tick;       // one millisecond passed
    logic rise;          // debounced rising edge
    logic fall;          // debounced falling edge
    logic sel_level;     // control level at the selected polarity
    logic [15:0] rate;   // telegram interval, zero treated as one
    ms_tick = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    sel_level = 1'b0;
    rate = 16'h0001;
    next_st = st;
    // two stage synchroniser, only stage two is looked at
    next_st.sync1 = i_ctl_pin;
    next_st.sync2 = st.sync1;
    // level accepted only after staying stable for the debounce time
    if (st.sync2 == st.level)
    begin
      next_st.deb_cnt = 16'h0000;
    end
    else if (st.deb_cnt == DEB_LAST)
    begin
      next_st.deb_cnt = 16'h0000;
      next_st.level = st.sync2;
    end
    else
    begin
      next_st.deb_cnt = st.deb_cnt + 16'h0001;
    end
    next_st.level_d = st.level;
    rise = st.level & ~st.level_d;
    fall = ~st.level & st.level_d;
    // polarity: 1 selects high, 0 selects low
    sel_level = i_ctl_polarity ? st.level : ~st.level;
    // duplex dependent permissions
    next_st.half_duplex = ~i_full_duplex;
    next_st.auto_ok = i_full_duplex & i_auto_tx_req;
    next_st.fw_ok = ~i_full_duplex & i_fw_update_req;
    next_st.fw_refused = i_full_duplex & i_fw_update_req;
    // sdi needs half duplex and the line held low by the host
    next_st.sdi_mode = ~i_full_duplex & (i_ctl_func == CLIM_CTL_SDI) & ~st.level;
    // heating control in any duplex mode; other functions release it
    case (i_ctl_func)
      CLIM_CTL_HEAT:
      begin
        next_st.heat_off = sel_level;
      end
      default:
      begin
        next_st.heat_off = 1'b0;
      end
    endcase
    // millisecond timebase for telegram intervals
    if (st.ms_cnt == MS_LAST)
    begin
      next_st.ms_cnt = 16'h0000;
      ms_tick = 1'b1;
    end
    else
    begin
      next_st.ms_cnt = st.ms_cnt + 16'h0001;
    end
    if (i_nmea_rate_ms != 16'h0000)
    begin
      rate = i_nmea_rate_ms;
    end
    // telegram pulse is one cycle wide
    next_st.nmea_send = 1'b0;
    // automatic output at the configured interval, only full duplex
    if (ms_tick)
    begin
      if (st.rate_cnt >= rate - 16'h0001)
      begin
        next_st.rate_cnt = 16'h0000;
        if (i_auto_nmea_en && i_full_duplex)
        begin
          next_st.nmea_send = 1'b1;
        end
      end
      else
      begin
        next_st.rate_cnt = st.rate_cnt + 16'h0001;
      end
    end
    // control line triggered output, inhibited in half duplex
    if (i_full_duplex)
    begin
      case (i_ctl_func)
        CLIM_CTL_EDGE:
        begin
          if (i_ctl_polarity ? rise : fall)
          begin
            next_st.nmea_send = 1'b1;
          end
        end
        CLIM_CTL_LEVEL:
        begin
          // repeat at the output interval while level holds
          if (!sel_level)
          begin
            next_st.lvl_cnt = 16'h0000;
          end
          else if (ms_tick)
          begin
            if (st.lvl_cnt == 16'h0000)
            begin
              next_st.nmea_send = 1'b1;
            end
            next_st.lvl_cnt = (st.lvl_cnt >= rate - 16'h0001) ? 16'h0000 : st.lvl_cnt + 16'h0001;
          end
        end
        default:
        begin
          next_st.lvl_cnt = 16'h0000;
        end
      endcase
    end
    else
    begin
      next_st.lvl_cnt = 16'h0000;
    end
    // analog outputs only with the binary protocol
    next_st.ao_enable = (i_protocol == CLIM_PR_BINARY);
    // current output carries values only in half duplex
    next_st.ao_a_cur = ~i_full_duplex & ((i_ao_a_kind == CLIM_AO_I0_20) | (i_ao_a_kind == CLIM_AO_I4_20));
    next_st.ao_b_cur = ~i_full_duplex & ((i_ao_b_kind == CLIM_AO_I0_20) | (i_ao_b_kind == CLIM_AO_I4_20));
    // channel assignments are loadable
    if (i_chan_a_set)
    begin
      next_st.chan_a = i_chan_a;
    end
    if (i_chan_b_set)
    begin
      next_st.chan_b = i_chan_b;
    end
    // refresh both outputs on a fixed period
    next_st.ao_update = 1'b0;
    if (st.ana_cnt == ANA_LAST)
    begin
      next_st.ana_cnt = 24'h000000;
      if (st.ao_enable)
      begin
        next_st.ao_update = 1'b1;
        next_st.a_kind = i_ao_a_kind;
        // frequency is not offered on B; fall back to voltage
        next_st.b_kind = (i_ao_b_kind == CLIM_AO_FREQ) ? CLIM_AO_V0_10 : i_ao_b_kind;
        next_st.a_val = i_value_a * i_scale_a;
        next_st.b_val = i_value_b * i_scale_b;
      end
    end
    else
    begin
      next_st.ana_cnt = st.ana_cnt + 24'h000001;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      st <= '0;
      st.sync1 <= 1'b1;
      st.sync2 <= 1'b1;
      st.level <= 1'b1;
      st.level_d <= 1'b1;
      st.half_duplex <= 1'b1;
      st.a_kind <= CLIM_AO_I4_20;
      st.b_kind <= CLIM_AO_I4_20;
      st.chan_a <= CHAN_A_DEFAULT;
      st.chan_b <= CHAN_B_DEFAULT;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from the state record
  assign o_half_duplex = st.half_duplex;
  assign o_sdi_mode = st.sdi_mode;
  assign o_fw_update_ok = st.fw_ok;
  assign o_fw_update_refused = st.fw_refused;
  assign o_auto_tx_ok = st.auto_ok;
  assign o_ctl_level = st.level;
  assign o_heat_force_off = st.heat_off;
  assign o_nmea_send = st.nmea_send;
  assign o_ao_enable = st.ao_enable;
  assign o_ao_a_current_ok = st.ao_a_cur;
  assign o_ao_b_current_ok = st.ao_b_cur;
  assign o_ao_update = st.ao_update;
  assign o_ao_a_kind = st.a_kind;
  assign o_ao_b_kind = st.b_kind;
  assign o_chan_a = st.chan_a;
  assign o_chan_b = st.chan_b;
  assign o_ao_a_value = st.a_val;
  assign o_ao_b_value = st.b_val;
endmodule : clim_core

// ### clim_asserts.sv
// assertion checker for the control line and mode logic
`timescale 1ns/1ns
module clim_asserts
  import clim_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // watched inputs
  input wire logic i_full_duplex,
  input wire clim_pkg::clim_proto_e i_protocol,
  input wire clim_pkg::clim_ctl_e i_ctl_func,
  input wire logic i_fw_update_req,
  input wire logic i_auto_tx_req,
  // watched outputs
  input wire logic o_half_duplex,
  input wire logic o_sdi_mode,
  input wire logic o_fw_update_ok,
  input wire logic o_fw_update_refused,
  input wire logic o_auto_tx_ok,
  input wire logic o_heat_force_off,
  input wire logic o_nmea_send,
  input wire logic o_ao_update,
  input wire logic o_ao_a_current_ok,
  input wire clim_pkg::clim_ao_e o_ao_b_kind
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // the edge after reset still shows reset values, hence the past reset guard
  a_half_mode: assert property (!$past(i_rst) |-> o_half_duplex == !$past(i_full_duplex))
    else $error("half duplex flag wrong");
  a_fw_accept: assert property (!$past(i_rst) |->
    o_fw_update_ok == ($past(i_fw_update_req) && !$past(i_full_duplex)))
    else $error("update accept wrong");
  a_fw_refuse: assert property (!$past(i_rst) |->
    o_fw_update_refused == ($past(i_fw_update_req) && $past(i_full_duplex)))
    else $error("update refusal wrong");
  a_auto_gate: assert property (!$past(i_rst) |->
    o_auto_tx_ok == ($past(i_auto_tx_req) && $past(i_full_duplex)))
    else $error("automatic telegram permission wrong");
  a_sdi_half: assert property (o_sdi_mode |-> !$past(i_full_duplex) && $past(i_ctl_func) == CLIM_CTL_SDI)
    else $error("serial sensor mode in full duplex");
  a_current_half: assert property (o_ao_a_current_ok |-> !$past(i_full_duplex))
    else $error("current output in full duplex");
  // the enable is registered once before the refresh pulse, so the protocol is two cycles back
  a_ao_binary: assert property (o_ao_update |-> $past(i_protocol, 2) == CLIM_PR_BINARY)
    else $error("analog update under other protocol");
  // automatic and control line telegrams may fall on neighbouring cycles, so only the duplex gate is checked
  a_nmea_full: assert property (o_nmea_send |-> $past(i_full_duplex))
    else $error("telegram in half duplex");
  a_heat_func: assert property (o_heat_force_off |-> $past(i_ctl_func) == CLIM_CTL_HEAT)
    else $error("heating forced off outside heating function");
  a_b_no_freq: assert property (o_ao_b_kind != CLIM_AO_FREQ)
    else $error("frequency kind on output b");
endmodule : clim_asserts
bind clim_core clim_asserts clim_asserts_i (.*);

// ### clim_contact.sv
// switch contact model on the control line
`timescale 1ns/1ns
module clim_contact
(
  // contact command
  input wire logic i_closed,
  // control pin, pulled up while open
  output logic o_pin
);
  // closed shorts to analog_return, open floats up to the pull-up
  assign o_pin = i_closed ? 1'b0 : 1'b1;
endmodule : clim_contact

// ### control_line_interface_mode_logic_tb.sv
// self-checking testbench of the control line and mode logic
`timescale 1ns/1ns
module control_line_interface_mode_logic_tb;
  import clim_pkg::*;
  // one table row: inputs then expected mode outputs
  typedef struct packed
  {
    logic fd;
    logic fw;
    logic at;
    clim_proto_e pr;
    clim_ao_e ka;
    clim_ao_e kb;
    logic [6:0] ex;
  } clim_row_s;
  logic i_clock, i_rst, pin, closed, fd, pol, fw, at, cs, ae;
  logic [15:0] rate;  // telegram interval in ms
  logic [15:0] ca_in; // channel number loaded into output a
  clim_proto_e pr;
  clim_ctl_e fn;
  clim_ao_e ka, kb;
  logic o_half, o_sdi, o_fwok, o_fwref, o_atok, o_lvl, o_heat, o_nmea, o_en, o_acur, o_bcur, o_upd;
  clim_ao_e o_ka, o_kb;
  logic [15:0] o_ca, o_cb;
  logic [31:0] o_va, o_vb;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_pulse = 0; // telegram pulses seen
  int n_upd = 0;   // analog refresh pulses seen
  int waited = 0;  // cycles until the debounced level fell
  clim_row_s rows [4] = '{
    '{1'b0, 1'b1, 1'b1, CLIM_PR_BINARY, CLIM_AO_I4_20, CLIM_AO_I0_20, 7'h67},
    '{1'b1, 1'b1, 1'b1, CLIM_PR_ASCII, CLIM_AO_V0_10, CLIM_AO_I4_20, 7'h18},
    '{1'b0, 1'b0, 1'b0, CLIM_PR_NMEA, CLIM_AO_FREQ, CLIM_AO_V2_10, 7'h40},
    '{1'b1, 1'b0, 1'b1, CLIM_PR_MB_RTU, CLIM_AO_I0_20, CLIM_AO_I0_20, 7'h08}};
  // clock at 50 MHz
  initial
  begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  clim_contact clim_contact_i (.i_closed(closed), .o_pin(pin));
  clim_core clim_core_i (.i_clock(i_clock), .i_rst(i_rst), .i_ctl_pin(pin), .i_full_duplex(fd), .i_protocol(pr),
    .i_ctl_func(fn), .i_ctl_polarity(pol), .i_auto_nmea_en(ae), .i_nmea_rate_ms(rate), .i_ao_a_kind(ka),
    .i_ao_b_kind(kb), .i_chan_a(ca_in), .i_chan_b(16'h01f5), .i_chan_a_set(cs), .i_chan_b_set(cs),
    .i_scale_a(16'h0002), .i_scale_b(16'h0003), .i_value_a(16'h0010), .i_value_b(16'h0020), .i_fw_update_req(fw),
    .i_auto_tx_req(at), .o_half_duplex(o_half), .o_sdi_mode(o_sdi), .o_fw_update_ok(o_fwok),
    .o_fw_update_refused(o_fwref), .o_auto_tx_ok(o_atok), .o_ctl_level(o_lvl), .o_heat_force_off(o_heat),
    .o_nmea_send(o_nmea), .o_ao_enable(o_en), .o_ao_a_current_ok(o_acur), .o_ao_b_current_ok(o_bcur),
    .o_ao_update(o_upd), .o_ao_a_kind(o_ka), .o_ao_b_kind(o_kb), .o_chan_a(o_ca), .o_chan_b(o_cb),
    .o_ao_a_value(o_va), .o_ao_b_value(o_vb));
  // compare and count
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // let registered outputs settle, sampled mid-cycle
  task settle;
    @(posedge i_clock);
    @(negedge i_clock);
  endtask : settle
  // single exit of the run
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // watchdog well past the one debounce span the run needs
  initial
  begin
    #2000000;
    n_mismatch++;
    report_and_stop;
  end
  // count one-cycle pulses mid-cycle, where they are settled
  always @(negedge i_clock)
  begin
    if (o_nmea === 1'b1)
    begin
      n_pulse <= n_pulse + 1;
    end
    if (o_upd === 1'b1)
    begin
      n_upd <= n_upd + 1;
    end
  end
  initial
  begin
    i_rst = 1'b1;
    closed = 1'b0;
    fd = 1'b0;
    pol = 1'b0;
    fw = 1'b0;
    at = 1'b0;
    cs = 1'b0;
    ae = 1'b0;
    rate = 16'h2710;
    ca_in = 16'h0190;
    pr = CLIM_PR_BINARY;
    fn = CLIM_CTL_HEAT;
    ka = CLIM_AO_I4_20;
    kb = CLIM_AO_I4_20;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    @(negedge i_clock);
    check("level", o_lvl, 1);
    check("half", o_half, 1);
    check("chan_a", o_ca, 16'h0190);
    check("chan_b", o_cb, 16'h01f4);
    check("kind_b", o_kb, CLIM_AO_I4_20);
    // mode permission table
    foreach (rows[r])
    begin
      @(posedge i_clock);
      fd <= rows[r].fd;
      fw <= rows[r].fw;
      at <= rows[r].at;
      pr <= rows[r].pr;
      ka <= rows[r].ka;
      kb <= rows[r].kb;
      settle;
      check("modes", {o_half, o_fwok, o_fwref, o_atok, o_en, o_acur, o_bcur}, rows[r].ex);
    end
    // one set pulse loads new channel numbers
    @(posedge i_clock);
    ca_in <= 16'h01a4;
    cs <= 1'b1;
    @(posedge i_clock);
    cs <= 1'b0;
    @(negedge i_clock);
    check("chan_a_set", o_ca, 16'h01a4);
    check("chan_b_set", o_cb, 16'h01f5);
    // full duplex, telegram every ms, falling edge trigger; the first ms tick comes before the debounced fall
    @(posedge i_clock);
    fd <= 1'b1;
    fw <= 1'b0;
    at <= 1'b0;
    ae <= 1'b1;
    rate <= 16'h0001;
    fn <= CLIM_CTL_EDGE;
    pol <= 1'b0;
    closed <= 1'b1;
    for (waited = 0; waited < 60000 && o_lvl !== 1'b0; waited++) @(negedge i_clock);
    check("level_low", o_lvl, 0);
    check("debounce_time", waited >= DEBOUNCE_CYC, 1);
    check("auto_count", n_pulse, 1);
    check("edge_wait", o_nmea, 0);
    @(negedge i_clock);
    check("edge_pulse", o_nmea, 1);
    @(negedge i_clock);
    check("edge_once", o_nmea, 0);
    // low level forces heating off in full and in half duplex
    @(posedge i_clock);
    fn <= CLIM_CTL_HEAT;
    settle;
    check("heat_full", o_heat, 1);
    @(posedge i_clock);
    fd <= 1'b0;
    settle;
    check("heat_half", o_heat, 1);
    @(posedge i_clock);
    pol <= 1'b1;
    settle;
    check("heat_auto", o_heat, 0);
    // with polarity low the level would force heating off, unless the function is disabled
    @(posedge i_clock);
    fn <= CLIM_CTL_OFF;
    pol <= 1'b0;
    settle;
    check("heat_ignored", o_heat, 0);
    @(posedge i_clock);
    fn <= CLIM_CTL_SDI;
    settle;
    check("sdi_half", o_sdi, 1);
    @(posedge i_clock);
    fd <= 1'b1;
    settle;
    check("sdi_full", o_sdi, 0);
    check("pulse_total", n_pulse, 2);
    // the run is far shorter than one refresh period, so the latched outputs keep their reset state
    check("upd_count", n_upd, 0);
    check("value_a", o_va, 0);
    check("value_b", o_vb, 0);
    check("kind_a", o_ka, CLIM_AO_I4_20);
    // reset in mid run restores the defaults
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    @(negedge i_clock);
    check("rst_chan_a", o_ca, 16'h0190);
    check("rst_level", o_lvl, 1);
    check("rst_sdi", o_sdi, 0);
    check("rst_half", o_half, 1);
    @(negedge i_clock);
    check("rst_full", o_half, 0);
    report_and_stop;
  end
endmodule : control_line_interface_mode_logic_tb
